// [include/rtcta_params.svh]
`ifndef RTCTA_PARAMS_SVH
`define RTCTA_PARAMS_SVH
// clock rate in MHz
`define RTCTA_CLK_MHZ        25
// low-frequency detection window, in us
`define RTCTA_DETECT_US      2000
// low-frequency edges needed to call it present
`define RTCTA_LF_MIN_EDGES   8'h08
// fixed pre-divider wrap value, divide by 64
`define RTCTA_PRE_LAST       6'h3f
// reset values
`define RTCTA_DIV_RST        20'h00000
`define RTCTA_TIME_RST       32'h00000000
`define RTCTA_ALARM_RST      32'hffffffff
// external irq routing codes
`define RTCTA_SEL_NONE       2'h0
`define RTCTA_SEL_TICK       2'h1
`define RTCTA_SEL_ALARM      2'h2
`define RTCTA_SEL_BOTH       2'h3
`endif

// [include/rtcta_pkg.sv]
package rtcta_pkg;
  // source detection after reset
  typedef enum logic [1:0] {
    RTCTA_DET_RUN  = 2'b00,
    RTCTA_DET_LF   = 2'b01,
    RTCTA_DET_MAIN = 2'b10
  } rtcta_det_e;
  // static configuration bits
  typedef struct packed {
    logic       rtc_enable;
    logic       osc_off_in_powerdown;
    logic       pd_keep_running;
    logic       powerdown_wake_config;
    logic       tick_ie;
    logic       alarm_ie;
    logic       cyc_ie;
    logic [1:0] ext_irq_source_select;
  } rtcta_cfg_s;
  // pending request flags
  typedef struct packed {
    logic tick;
    logic alarm;
    logic cyc;
  } rtcta_irq_s;
endpackage

// [rtl/rtcta_top.sv]
`include "rtcta_params.svh"
// =====================================================
module rtcta_top #(
  parameter int DIV_W      = 20,
  parameter int TIME_W     = 32,
  parameter int CYC_W      = 16,
  parameter int DETECT_CYC = `RTCTA_DETECT_US * `RTCTA_CLK_MHZ
) (
  // clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 rstn,
  // oscillator pins and oscillator controls
  input  wire logic                 main_osc_in,
  input  wire logic                 low_freq_osc_in,
  output logic                      low_freq_osc_out,
  output logic                      main_osc_en,
  output logic                      lf_osc_en,
  output logic                      lf_present,
  // chip power state
  input  wire logic                 powerdown,
  // configuration
  input  wire rtcta_pkg::rtcta_cfg_s cfg,
  input  wire logic [DIV_W-1:0]     tick_reload_value,
  input  wire logic [CYC_W-1:0]     cyc_count,
  // time and alarm loading
  input  wire logic                 time_load,
  input  wire logic [TIME_W-1:0]    time_load_value,
  input  wire logic                 alarm_load,
  input  wire logic [TIME_W-1:0]    alarm_load_value,
  // flag clears, one-cycle pulses
  input  wire rtcta_pkg::rtcta_irq_s irq_clr,
  // status
  output rtcta_pkg::rtcta_irq_s     irq_pending,
  output logic [TIME_W-1:0]         time_value,
  output logic [TIME_W-1:0]         alarm_value,
  output logic [DIV_W-1:0]          divider_value,
  output logic [DIV_W+TIME_W+5:0]   long_timer,
  // requests
  output logic                      tick_irq,
  output logic                      alarm_irq,
  output logic                      cyc_irq,
  output logic                      ext_irq,
  output logic                      wake_req
);

  // =====================================================
  // parameter checks
  // refused at elaboration, so a bad width never reaches the logic
  // the long timer layout assumes the documented widths
  if (DIV_W != 20 || TIME_W != 32 || CYC_W < 1 || DETECT_CYC < 2) begin : g_param_check
    $error("rtcta_top: unsupported parameter values");
  end

  // =====================================================
  // source detection
  rtcta_pkg::rtcta_det_e det_r;
  logic [31:0]           det_cnt_r;
  logic [7:0]            lf_edges_r;
  logic                  lf_prev_r;
  logic                  lf_edge;
  logic                  use_lf;

  // pin sampled synchronously; edge seen on rising transitions
  assign lf_edge = low_freq_osc_in & ~lf_prev_r;
  assign use_lf  = (det_r == rtcta_pkg::RTCTA_DET_LF);

  // a pin stuck high after reset gives one false edge, far below the threshold
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      lf_prev_r <= 1'b0;
    end else begin
      lf_prev_r <= low_freq_osc_in;
    end
  end

  // window after reset; decision held until next reset
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      det_r      <= rtcta_pkg::RTCTA_DET_RUN;
      det_cnt_r  <= 32'h00000000;
      lf_edges_r <= 8'h00;
    end else begin
      case (det_r)
        rtcta_pkg::RTCTA_DET_RUN: begin
          det_cnt_r <= det_cnt_r + 32'h00000001;
          if (lf_edge && lf_edges_r != 8'hff) begin
            lf_edges_r <= lf_edges_r + 8'h01;
          end
          if (lf_edges_r >= `RTCTA_LF_MIN_EDGES) begin
            det_r <= rtcta_pkg::RTCTA_DET_LF;
          end else if (det_cnt_r == 32'(DETECT_CYC - 1)) begin
            det_r <= rtcta_pkg::RTCTA_DET_MAIN;
          end
        end
        default: begin
          det_r <= det_r;
        end
      endcase
    end
  end

  // =====================================================
  // oscillator control
  // main_osc_in is not sensed: core_clk is already derived from it
  logic src_off;
  // stopping the source oscillator also freezes the chain
  assign src_off = powerdown & (cfg.osc_off_in_powerdown | ~cfg.rtc_enable);

  always_comb begin
    main_osc_en = 1'b1;
    lf_osc_en   = 1'b1;
    if (powerdown) begin
      if (!cfg.rtc_enable) begin
        main_osc_en = 1'b0;
        lf_osc_en   = 1'b0;
      end else if (use_lf) begin
        main_osc_en = 1'b0;
        lf_osc_en   = ~cfg.osc_off_in_powerdown;
      end else begin
        main_osc_en = ~cfg.osc_off_in_powerdown;
      end
    end
  end

  // inverter drive back to the crystal while enabled
  assign low_freq_osc_out = lf_osc_en & ~low_freq_osc_in;
  assign lf_present       = use_lf;

  // =====================================================
  // counting enable
  logic run;
  // in power down the chain runs only when asked to
  assign run = cfg.rtc_enable & ~src_off & (~powerdown | cfg.pd_keep_running);

  // =====================================================
  // fixed divide by 64
  logic [5:0] pre_r;
  logic       step;

  // low-frequency source steps once per edge, else per 64 core cycles
  assign step = run & (use_lf ? lf_edge : (pre_r == `RTCTA_PRE_LAST));

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pre_r <= 6'h00;
    end else if (run && !use_lf) begin
      pre_r <= pre_r + 6'h01;
    end
  end

  // =====================================================
  // 20-bit reloadable divider
  logic [DIV_W-1:0] div_r;
  logic             tick;

  assign tick = step & (div_r == '0);

  // counts down, reload on the tick sets the period to reload+1 steps
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      div_r <= `RTCTA_DIV_RST;
    end else if (tick) begin
      div_r <= tick_reload_value;
    end else if (step) begin
      div_r <= div_r - 1'b1;
    end
  end

  // =====================================================
  // time counter and alarm
  logic [TIME_W-1:0] time_r;
  logic [TIME_W-1:0] alarm_r;
  logic              match;
  logic              match_q_r;
  logic              alarm_ev;

  // software load wins over a tick in the same cycle
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      time_r <= `RTCTA_TIME_RST;
    end else if (time_load) begin
      time_r <= time_load_value;
    end else if (tick) begin
      time_r <= time_r + 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      alarm_r <= `RTCTA_ALARM_RST;
    end else if (alarm_load) begin
      alarm_r <= alarm_load_value;
    end
  end

  // event on the start of equality, so a cleared flag stays clear
  assign match    = (time_r == alarm_r);
  assign alarm_ev = match & ~match_q_r;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      match_q_r <= 1'b1;
    end else begin
      match_q_r <= match;
    end
  end

  // =====================================================
  // cyclic tick count
  logic [CYC_W-1:0] cyc_r;
  logic             cyc_ev;

  // a count of zero behaves as one
  assign cyc_ev = tick & (cyc_r + 1'b1 >= cyc_count);

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cyc_r <= '0;
    end else if (cyc_ev) begin
      cyc_r <= '0;
    end else if (tick) begin
      cyc_r <= cyc_r + 1'b1;
    end
  end

  // =====================================================
  // pending flags; set beats clear
  rtcta_pkg::rtcta_irq_s flag_r;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      flag_r <= '0;
    end else begin
      flag_r.tick  <= (tick && cfg.tick_ie) | (flag_r.tick & ~irq_clr.tick);
      flag_r.alarm <= (alarm_ev && cfg.alarm_ie) | (flag_r.alarm & ~irq_clr.alarm);
      flag_r.cyc   <= (cyc_ev && cfg.cyc_ie) | (flag_r.cyc & ~irq_clr.cyc);
    end
  end

  // =====================================================
  // routing and wake
  logic ext_irq_r;
  logic wake_r;

  // external irq follows the selected pending flags
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ext_irq_r <= 1'b0;
    end else begin
      if (cfg.ext_irq_source_select == `RTCTA_SEL_TICK) begin
        ext_irq_r <= flag_r.tick;
      end else if (cfg.ext_irq_source_select == `RTCTA_SEL_ALARM) begin
        ext_irq_r <= flag_r.alarm;
      end else if (cfg.ext_irq_source_select == `RTCTA_SEL_BOTH) begin
        ext_irq_r <= flag_r.tick | flag_r.alarm;
      end else begin
        ext_irq_r <= 1'b0;
      end
    end
  end

  // programmed delay is the routed tick/alarm request or the cyclic count reaching its figure
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wake_r <= 1'b0;
    end else begin
      wake_r <= powerdown & cfg.powerdown_wake_config & (ext_irq_r | flag_r.cyc);
    end
  end

  // =====================================================
  // outputs
  assign irq_pending   = flag_r;
  assign tick_irq      = flag_r.tick;
  assign alarm_irq     = flag_r.alarm;
  assign cyc_irq       = flag_r.cyc;
  assign ext_irq       = ext_irq_r;
  assign wake_req      = wake_r;
  assign time_value    = time_r;
  assign alarm_value   = alarm_r;
  assign divider_value = div_r;
  // down-counting divider folded to an up count for the long timer
  assign long_timer    = {time_r, ~div_r, pre_r};

endmodule

// [sim/rtcta_assertions.sv]
`include "rtcta_params.svh"
// ==========================================
// port-level checks of the clock block
module rtcta_checker #(
  parameter int DIV_W  = 20,
  parameter int TIME_W = 32
) (
  // clock and reset
  input wire logic                    core_clk,
  input wire logic                    rstn,
  // controls
  input wire logic                    powerdown,
  input wire rtcta_pkg::rtcta_cfg_s   cfg,
  input wire logic                    time_load,
  input wire logic [TIME_W-1:0]       time_load_value,
  input wire logic                    alarm_load,
  input wire logic [TIME_W-1:0]       alarm_load_value,
  input wire rtcta_pkg::rtcta_irq_s   irq_clr,
  // status and requests
  input wire logic [TIME_W-1:0]       time_value,
  input wire logic [TIME_W-1:0]       alarm_value,
  input wire logic [DIV_W+TIME_W+5:0] long_timer,
  input wire logic                    main_osc_en,
  input wire logic                    lf_osc_en,
  input wire logic                    lf_present,
  input wire logic                    tick_irq,
  input wire logic                    alarm_irq,
  input wire logic                    cyc_irq,
  input wire logic                    ext_irq,
  input wire logic                    wake_req
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // oscillators only stop inside power down
  osc_run_a: assert property (!powerdown |-> main_osc_en && lf_osc_en)
    else $error("oscillator off outside power down");
  pd_main_a: assert property (powerdown && cfg.rtc_enable && !lf_present |->
    main_osc_en == !cfg.osc_off_in_powerdown)
    else $error("main oscillator state wrong in power down");
  pd_lf_a: assert property (powerdown && cfg.rtc_enable && lf_present |->
    !main_osc_en && lf_osc_en == !cfg.osc_off_in_powerdown)
    else $error("oscillators wrong in power down on low-frequency source");
  pd_off_a: assert property (powerdown && !cfg.rtc_enable |-> !main_osc_en && !lf_osc_en)
    else $error("oscillators not stopped while disabled");
  // loads land one cycle later
  time_load_a: assert property (time_load |=> time_value == $past(time_load_value))
    else $error("time load lost");
  alarm_load_a: assert property (alarm_load |=> alarm_value == $past(alarm_load_value))
    else $error("alarm load lost");
  alarm_set_a: assert property (cfg.alarm_ie && time_value == alarm_value &&
    $past(time_value != alarm_value) |=> alarm_irq)
    else $error("alarm flag not raised on match");
  // any change without a load is a step of one, wrap included
  time_step_a: assert property (!time_load ##1 time_value != $past(time_value) |->
    time_value == $past(time_value) + 1'b1)
    else $error("time counter stepped wrongly");
  flag_hold_a: assert property (tick_irq && !irq_clr.tick |=> tick_irq)
    else $error("tick flag dropped without clear");
  // routing is judged only once the select has settled
  ext_tick_a: assert property ((cfg.ext_irq_source_select == `RTCTA_SEL_TICK) [*2] |->
    ext_irq == $past(tick_irq))
    else $error("external request does not follow tick flag");
  timer_top_a: assert property (long_timer[DIV_W+TIME_W+5:DIV_W+6] == time_value)
    else $error("long timer top differs from time");
  wake_a: assert property (wake_req == $past(powerdown && cfg.powerdown_wake_config && (ext_irq || cyc_irq)))
    else $error("wake request wrong");
  // main scenarios reached
  tick_c: cover property ($rose(tick_irq));
  alarm_c: cover property ($rose(alarm_irq));
  cyc_c: cover property ($rose(cyc_irq));
  wake_c: cover property ($rose(wake_req));
endmodule

bind rtcta_top rtcta_checker #(.DIV_W(DIV_W), .TIME_W(TIME_W)) i_chk (
  .core_clk(core_clk), .rstn(rstn), .powerdown(powerdown), .cfg(cfg),
  .time_load(time_load), .time_load_value(time_load_value), .alarm_load(alarm_load),
  .alarm_load_value(alarm_load_value), .irq_clr(irq_clr), .time_value(time_value),
  .alarm_value(alarm_value), .long_timer(long_timer), .main_osc_en(main_osc_en),
  .lf_osc_en(lf_osc_en), .lf_present(lf_present), .tick_irq(tick_irq), .alarm_irq(alarm_irq),
  .cyc_irq(cyc_irq), .ext_irq(ext_irq), .wake_req(wake_req)
);

// [sim/rtcta_top_tb.sv]
`include "rtcta_params.svh"
// ==========================================
// bench for the clock block, main source then low-frequency source
module rtcta_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0, rstn = 1'b0, lf_in = 1'b0, pd = 1'b0;
  logic tl = 1'b0, al = 1'b0;
  rtcta_pkg::rtcta_cfg_s cfg = '0;
  rtcta_pkg::rtcta_irq_s clr = '0, pend;
  logic [19:0] rel = 20'h00003, dv;
  logic [15:0] cyc_n = 16'h0003;
  logic [31:0] tlv = 32'h00000000, alv = 32'h00000000, tv, av, t0;
  logic [57:0] lt, lt0;
  logic        tirq, airq, cirq, eirq, wk, men, len, lfp, lfo;
  int          fails = 0, checked = 0, cyc = 0, p;
  // short detection window keeps the run brief
  rtcta_top #(.DETECT_CYC(64)) i_dut (
    .core_clk(core_clk), .rstn(rstn), .main_osc_in(1'b0), .low_freq_osc_in(lf_in),
    .low_freq_osc_out(lfo), .main_osc_en(men), .lf_osc_en(len), .lf_present(lfp),
    .powerdown(pd), .cfg(cfg), .tick_reload_value(rel), .cyc_count(cyc_n),
    .time_load(tl), .time_load_value(tlv), .alarm_load(al), .alarm_load_value(alv),
    .irq_clr(clr), .irq_pending(pend), .time_value(tv), .alarm_value(av),
    .divider_value(dv), .long_timer(lt), .tick_irq(tirq), .alarm_irq(airq),
    .cyc_irq(cirq), .ext_irq(eirq), .wake_req(wk)
  );
  always #20 core_clk = ~core_clk;
  // hang guard, well above the few thousand cycles needed
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 30000) begin
      fails++;
      final_report;
    end
  end
  task chk(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task final_report;
    if (fails == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  function logic flag(input int w);
    return (w == 0) ? tirq : (w == 1) ? airq : cirq;
  endfunction
  // one-cycle clear of every flag
  task clr_all;
    @(negedge core_clk) clr = 3'b111;
    @(negedge core_clk) clr = 3'b000;
  endtask
  task wait_flag(input int w, output int c);
    c = 0;
    while (flag(w) !== 1'b1 && c < 3000) begin
      @(negedge core_clk);
      c++;
    end
  endtask
  // third rise is measured so a reload change has settled
  task period(input int w, output int q);
    wait_flag(w, q);
    clr_all;
    wait_flag(w, q);
    clr_all;
    wait_flag(w, q);
    q = q + 2;
  endtask
  task t_detect;
    repeat (80) @(negedge core_clk);
    chk(lfp, 1'b0);
    chk({men, len}, 2'b11);
  endtask
  task t_tick;
    cfg.rtc_enable = 1'b1;
    cfg.tick_ie = 1'b1;
    period(0, p);
    chk(p, 256);
    chk(dv, 20'h00003);
    rel = 20'h00000;
    period(0, p);
    chk(p, 64);
    t0 = tv;
    clr_all;
    wait_flag(0, p);
    chk(tv, t0 + 32'h1);
    @(negedge core_clk) {tl, tlv} = {1'b1, 32'hffffffff};
    @(negedge core_clk) tl = 1'b0;
    chk(tv, 32'hffffffff);
    clr_all;
    wait_flag(0, p);
    chk(tv, 32'h0);
    repeat (100) @(negedge core_clk);
    chk(tirq, 1'b1);
    cfg.ext_irq_source_select = `RTCTA_SEL_TICK;
    repeat (2) @(negedge core_clk);
    chk(eirq, 1'b1);
    cfg.tick_ie = 1'b0;
    clr_all;
    repeat (70) @(negedge core_clk);
    chk(tirq, 1'b0);
  endtask
  // alarm, then routing, wake and oscillator control on the pending alarm
  task t_alarm;
    cfg.alarm_ie = 1'b1;
    @(negedge core_clk) {tl, tlv, al, alv} = {1'b1, 32'h5, 1'b1, 32'h7};
    @(negedge core_clk) {tl, al} = 2'b00;
    chk(av, 32'h7);
    clr_all;
    wait_flag(1, p);
    chk(tv, 32'h7);
    chk(pend, 3'b010);
    for (int s = 0; s < 4; s++) begin
      @(negedge core_clk) cfg.ext_irq_source_select = 2'(s);
      repeat (2) @(negedge core_clk);
      chk(eirq, s >= 2);
    end
    cfg.ext_irq_source_select = `RTCTA_SEL_ALARM;
    {cfg.powerdown_wake_config, cfg.pd_keep_running, pd} = 3'b111;
    repeat (3) @(negedge core_clk);
    chk(wk, 1'b1);
    chk(men, 1'b1);
    @(negedge core_clk) cfg.osc_off_in_powerdown = 1'b1;
    #1;
    chk(men, 1'b0);
    @(negedge core_clk) cfg.rtc_enable = 1'b0;
    #1;
    chk({men, len}, 2'b00);
    chk(lfo, 1'b0);
    @(negedge core_clk) {pd, cfg.rtc_enable, cfg.osc_off_in_powerdown} = 3'b010;
    clr_all;
    chk(airq, 1'b0);
  endtask
  task t_cyclic;
    cfg.cyc_ie = 1'b1;
    period(2, p);
    chk(p, 192);
    chk(lt[57:26], tv);
    lt0 = lt;
    @(negedge core_clk);
    chk(lt, lt0 + 58'h1);
  endtask
  task toggle_lf(input int n);
    repeat (n) begin
      repeat (2) @(negedge core_clk);
      lf_in = ~lf_in;
    end
  endtask
  // second reset with a live low-frequency clock on the pin
  task t_lf;
    rstn = 1'b0;
    cfg = '0;
    pd = 1'b0;
    rel = 20'h00000;
    repeat (2) @(negedge core_clk);
    rstn = 1'b1;
    toggle_lf(20);
    chk(lfp, 1'b1);
    chk(tv, 32'h0);
    cfg.rtc_enable = 1'b1;
    toggle_lf(10);
    chk(tv, 32'h5);
    {pd, cfg.osc_off_in_powerdown} = 2'b11;
    #1;
    chk({men, len, lfo}, 3'b000);
    {cfg.osc_off_in_powerdown, cfg.pd_keep_running} = 2'b01;
    #1;
    chk({men, len, lfo}, {2'b01, ~lf_in});
    toggle_lf(4);
    chk(tv, 32'h7);
    pd = 1'b0;
  endtask
  initial begin
    repeat (10) @(negedge core_clk);
    rstn = 1'b1;
    t_detect;
    t_tick;
    t_alarm;
    t_cyclic;
    t_lf;
    final_report;
  end
endmodule
